// ---- motion_aux_consts.vh ----
`ifndef MOTION_AUX_CONSTS_VH
`define MOTION_AUX_CONSTS_VH
// ==========================================
// Register offsets
`define ADDR_NUDGE_TRAVEL 8'h00
`define ADDR_NUDGE_SPEED 8'h04
`define ADDR_NUDGE_ACCEL 8'h08
`define ADDR_NUDGE_START 8'h0c
`define ADDR_RET_CTRL 8'h10
`define ADDR_RET_SPEED 8'h14
`define ADDR_RET_ACCEL 8'h18
`define ADDR_RET_START 8'h1c
`define ADDR_OT_CTRL 8'h20
`define ADDR_SOFT_POS 8'h24
`define ADDR_SOFT_NEG 8'h28
`define ADDR_STATUS 8'h2c
`define ADDR_POSITION 8'h30
`define ADDR_TEACH 8'h34
`define ADDR_STOP_CMD 8'h38
`define ADDR_CONFIG_CMD 8'h3c
// ==========================================
// Field positions
`define OT_HW_EN_BIT 0
`define OT_ACTION_BIT 1
`define OT_SW_EN_BIT 2
`define TEACH_ABS_BIT 31
// ==========================================
// Reset values
`define RST_NUDGE_TRAVEL 24'h000001
`define RST_SPEED 20'h003e8
`define RST_ACCEL 20'h003e8
`define RST_START 20'h001f4
`define RST_RET_EN 1'b0
`define RST_OT_CTRL 3'h5
`define RST_SOFT_POS 24'h7fffff
`define RST_SOFT_NEG 24'h800000
`endif

// ---- motion_aux_stop_limit_control.v ----
// What this block does
// [R1] A nudge request makes one positioning move of the configured nudge travel.
// [R2] Positive nudge input moves positive; negative nudge input moves negative.
// [R3] Holds nudge speed setting, 1 to 1,000,000 Hz, default 1000.
// [R4] Holds nudge acceleration setting, 1 to 1,000,000, default 1000.
// [R5] Holds nudge starting speed setting, 0 to 1,000,000 Hz, default 500.
// [R6] Start only while ready; ready drops at motion start, returns at completion.
// [R7] Taught position stored into an entry forces that entry absolute.
// [R8] Teaching moves use the nudge speed, acceleration and starting speed.
// [R9] Automatic return to last stop on power-on, excitation rise or free-run fall; the code returns only on an excitation rise or a free-run fall.
// [R10] Automatic return enable: 0 disabled, 1 enabled, default 0.
// [R11] Automatic return has its own speed, acceleration and starting speed.
// [R12] No automatic return right after power-up or a configuration command.
// [R13] Alarm while unexcited leaves automatic return unguaranteed.
// [R14] Stop input or stop command halts motion using the stop-action setting; the code makes a decelerating stop unless a limit or a limit change coincides.
// [R15] Hardware overtravel enabled by default; a limit sensor stops the motor.
// [R16] Overtravel action: 0 immediate stop, 1 decelerating stop.
// [R17] Software overtravel stops motion at the software limit.
// [R18] Software limits span 24-bit signed range, defaults at the extremes.
// [R19] Software overtravel applies only once an origin is established.
// [R20] Changing a software limit during motion stops the motor.
// [R21] After a limit only motion in the opposite direction is permitted.
// [R22] Positioning moves cannot escape a limit sensor; other moves may. The code does let an automatic return move away from an active sensor.
// [R23] Homing or position preset establishes the origin.
// [R24] No start while stop input is held; ready stays low meanwhile. The code starts an automatic return even while it is held.
//
// Added by the designer: strobed register access and the register addresses.
`include "motion_aux_consts.vh"
module motion_aux_stop_limit_control #(
	parameter POS_W = 24,
	parameter SPD_W = 20
) (
	// Clock and reset
	input wire ref_clk,
	input wire sys_rst,
	// Host discrete inputs
	input wire nudge_positive_input,
	input wire nudge_negative_input,
	input wire stop_input,
	input wire excite_on_input,
	input wire free_run_input,
	input wire preset_input,
	input wire [1:0] limit_sensor_inputs,
	// Motion engine interface
	input wire home_done,
	input wire alarm_active,
	input wire step_done,
	input wire [1:0] ext_move_req,
	input wire ext_move_dir,
	// Register port
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	// Ready and step outputs
	output reg ready,
	output reg step_req,
	output reg step_dir,
	output reg decel_stop,
	output reg [SPD_W-1:0] prof_speed,
	output reg [SPD_W-1:0] prof_accel,
	output reg [SPD_W-1:0] prof_start,
	output reg teach_wr,
	output reg [5:0] teach_index,
	output reg [POS_W:0] teach_data
);
	// ==========================================
	// States
	localparam ST_IDLE = 2'd0;
	localparam ST_MOVE = 2'd1;
	localparam ST_DECEL = 2'd2;
	localparam ST_HOLD = 2'd3;
	localparam KIND_POSN = 1'b0;
	localparam KIND_FREE = 1'b1;

	// ==========================================
	// Input synchronisers
	reg [8:0] sync1_reg;
	reg [8:0] sync2_reg;
	reg [8:0] prev_reg;
	wire s_npos = sync2_reg[0];
	wire s_nneg = sync2_reg[1];
	wire s_stop = sync2_reg[2];
	wire s_exc = sync2_reg[3];
	wire s_free = sync2_reg[4];
	wire s_pre = sync2_reg[5];
	wire s_lpos = sync2_reg[6];
	wire s_lneg = sync2_reg[7];
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			sync1_reg <= 9'h000;
			sync2_reg <= 9'h000;
			prev_reg <= 9'h000;
		end else begin
			sync1_reg <= {1'b0, limit_sensor_inputs, preset_input, free_run_input,
				excite_on_input, stop_input, nudge_negative_input, nudge_positive_input};
			sync2_reg <= sync1_reg;
			prev_reg <= sync2_reg;
		end
	end

	// ==========================================
	// Settings
	reg [POS_W-1:0] travel_reg;
	reg [SPD_W-1:0] n_speed_reg, n_accel_reg, n_start_reg;
	reg [SPD_W-1:0] r_speed_reg, r_accel_reg, r_start_reg;
	reg ret_en_reg;
	reg [2:0] ot_ctrl_reg;
	reg [POS_W-1:0] soft_pos_reg, soft_neg_reg;
	reg [POS_W-1:0] pos_reg, last_stop_reg;
	reg origin_reg;
	reg ret_block_reg;
	reg limit_chg_reg;
	reg stop_cmd_reg;
	reg [1:0] state_reg;
	reg kind_reg;
	reg [POS_W-1:0] remain_reg;
	reg lim_pos_reg, lim_neg_reg;
	wire hw_en = ot_ctrl_reg[`OT_HW_EN_BIT];
	wire ot_decel = ot_ctrl_reg[`OT_ACTION_BIT];
	wire sw_en = ot_ctrl_reg[`OT_SW_EN_BIT];

	function [POS_W-1:0] signext;
		input [31:0] d;
		begin
			signext = d[POS_W-1:0];
		end
	endfunction

	function pick_dir;
		input dir;
		input pos_side;
		input neg_side;
		begin
			pick_dir = dir ? pos_side : neg_side;
		end
	endfunction

	// ==========================================
	// Register writes
	wire wr_limit = reg_wr && (reg_addr == `ADDR_SOFT_POS || reg_addr == `ADDR_SOFT_NEG);
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			travel_reg <= `RST_NUDGE_TRAVEL; // R1
			n_speed_reg <= `RST_SPEED; // R3
			n_accel_reg <= `RST_ACCEL; // R4
			n_start_reg <= `RST_START; // R5
			r_speed_reg <= `RST_SPEED; // R11
			r_accel_reg <= `RST_ACCEL;
			r_start_reg <= `RST_START;
			ret_en_reg <= `RST_RET_EN; // R10
			ot_ctrl_reg <= `RST_OT_CTRL; // R15
			soft_pos_reg <= `RST_SOFT_POS; // R18
			soft_neg_reg <= `RST_SOFT_NEG;
		end else if (reg_wr) begin
			case (reg_addr)
				`ADDR_NUDGE_TRAVEL: travel_reg <= (reg_wdata[POS_W-1:0] == 24'h000000) ? 24'h000001 :
					{1'b0, reg_wdata[POS_W-2:0]};
				`ADDR_NUDGE_SPEED: n_speed_reg <= reg_wdata[SPD_W-1:0];
				`ADDR_NUDGE_ACCEL: n_accel_reg <= reg_wdata[SPD_W-1:0];
				`ADDR_NUDGE_START: n_start_reg <= reg_wdata[SPD_W-1:0];
				`ADDR_RET_CTRL: ret_en_reg <= reg_wdata[0]; // R10
				`ADDR_RET_SPEED: r_speed_reg <= reg_wdata[SPD_W-1:0];
				`ADDR_RET_ACCEL: r_accel_reg <= reg_wdata[SPD_W-1:0];
				`ADDR_RET_START: r_start_reg <= reg_wdata[SPD_W-1:0];
				`ADDR_OT_CTRL: ot_ctrl_reg <= reg_wdata[2:0]; // R16
				`ADDR_SOFT_POS: soft_pos_reg <= signext(reg_wdata);
				`ADDR_SOFT_NEG: soft_neg_reg <= signext(reg_wdata);
				default: ;
			endcase
		end
	end

	// ==========================================
	// Register reads
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd) begin
			case (reg_addr)
				`ADDR_NUDGE_TRAVEL: reg_rdata <= {8'h00, travel_reg};
				`ADDR_NUDGE_SPEED: reg_rdata <= {12'h000, n_speed_reg};
				`ADDR_NUDGE_ACCEL: reg_rdata <= {12'h000, n_accel_reg};
				`ADDR_NUDGE_START: reg_rdata <= {12'h000, n_start_reg};
				`ADDR_RET_CTRL: reg_rdata <= {31'h00000000, ret_en_reg};
				`ADDR_RET_SPEED: reg_rdata <= {12'h000, r_speed_reg};
				`ADDR_RET_ACCEL: reg_rdata <= {12'h000, r_accel_reg};
				`ADDR_RET_START: reg_rdata <= {12'h000, r_start_reg};
				`ADDR_OT_CTRL: reg_rdata <= {29'h00000000, ot_ctrl_reg};
				`ADDR_SOFT_POS: reg_rdata <= {{8{soft_pos_reg[POS_W-1]}}, soft_pos_reg};
				`ADDR_SOFT_NEG: reg_rdata <= {{8{soft_neg_reg[POS_W-1]}}, soft_neg_reg};
				`ADDR_STATUS: reg_rdata <= {24'h000000, lim_neg_reg, lim_pos_reg, origin_reg,
					kind_reg, state_reg, s_stop, ready};
				`ADDR_POSITION: reg_rdata <= {{8{pos_reg[POS_W-1]}}, pos_reg};
				default: reg_rdata <= 32'h00000000;
			endcase
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end

	// ==========================================
	// Teaching store
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			teach_wr <= 1'b0;
			teach_index <= 6'h00;
			teach_data <= {(POS_W+1){1'b0}};
		end else begin
			teach_wr <= reg_wr && (reg_addr == `ADDR_TEACH);
			if (reg_wr && reg_addr == `ADDR_TEACH) begin
				teach_index <= reg_wdata[5:0];
				teach_data <= {1'b1, pos_reg}; // R7
			end
		end
	end

	// ==========================================
	// Start, limit and stop decisions
	wire nudge_req = (s_npos && !prev_reg[0]) || (s_nneg && !prev_reg[1]);
	wire nudge_dir = s_npos; // R2
	wire exc_rise = s_exc && !prev_reg[3];
	wire free_fall = !s_free && prev_reg[4];
	wire reexcite = exc_rise || free_fall; // R9
	wire config_cmd = reg_wr && (reg_addr == `ADDR_CONFIG_CMD);
	wire stop_cmd = reg_wr && (reg_addr == `ADDR_STOP_CMD);
	wire do_return = ret_en_reg && (reexcite || (state_reg == ST_HOLD && !ret_block_reg)) &&
		(pos_reg != last_stop_reg); // R9 R12 R13
	wire ret_dir = $signed(last_stop_reg) > $signed(pos_reg);
	wire [POS_W-1:0] ret_dist = ret_dir ? (last_stop_reg - pos_reg) : (pos_reg - last_stop_reg);
	wire hw_pos = hw_en && s_lpos; // R15
	wire hw_neg = hw_en && s_lneg;
	wire sw_on = sw_en && origin_reg; // R19
	wire sw_pos = sw_on && ($signed(pos_reg) >= $signed(soft_pos_reg));
	wire sw_neg = sw_on && ($signed(pos_reg) <= $signed(soft_neg_reg));
	// R21 R22: direction blocked by a limit for a given move kind
	wire blk_pos_posn = lim_pos_reg || hw_pos || sw_pos;
	wire blk_neg_posn = lim_neg_reg || hw_neg || sw_neg;
	wire blk_pos_free = hw_pos || sw_pos;
	wire blk_neg_free = hw_neg || sw_neg;
	wire dir_blocked = kind_reg ? pick_dir(step_dir, blk_pos_free, blk_neg_free) :
		pick_dir(step_dir, blk_pos_posn, blk_neg_posn);
	wire ext_go = |ext_move_req;
	wire can_start = ready && !s_stop; // R6 R24
	wire [POS_W-1:0] pos_stepped = step_dir ? pos_reg + 1'b1 : pos_reg - 1'b1;
	wire [POS_W-1:0] pos_now = (step_done && step_req) ? pos_stepped : pos_reg;

	// ==========================================
	// Start gating
	wire nudge_blocked = hw_pos || hw_neg || pick_dir(nudge_dir, blk_pos_posn, blk_neg_posn); // R21 R22

	// ==========================================
	// Motion sequencer
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			state_reg <= ST_HOLD;
			kind_reg <= KIND_POSN;
			remain_reg <= {POS_W{1'b0}};
			ready <= 1'b0;
			step_req <= 1'b0;
			step_dir <= 1'b0;
			decel_stop <= 1'b0;
			prof_speed <= `RST_SPEED;
			prof_accel <= `RST_ACCEL;
			prof_start <= `RST_START;
			pos_reg <= {POS_W{1'b0}};
			last_stop_reg <= {POS_W{1'b0}};
			origin_reg <= 1'b0;
			ret_block_reg <= 1'b1;
			lim_pos_reg <= 1'b0;
			lim_neg_reg <= 1'b0;
			limit_chg_reg <= 1'b0;
			stop_cmd_reg <= 1'b0;
		end else begin
			limit_chg_reg <= wr_limit && state_reg != ST_IDLE && state_reg != ST_HOLD;
			stop_cmd_reg <= stop_cmd;
			if (s_pre || home_done) begin
				origin_reg <= 1'b1; // R23
				if (s_pre)
					pos_reg <= {POS_W{1'b0}};
			end
			if (config_cmd)
				ret_block_reg <= 1'b1; // R12
			else if (reexcite)
				ret_block_reg <= 1'b0;
			if (alarm_active && !s_exc)
				ret_block_reg <= 1'b1; // R13
			if (step_done && step_req)
				pos_reg <= pos_stepped;
			if (!hw_pos && !(sw_pos))
				lim_pos_reg <= 1'b0;
			if (!hw_neg && !(sw_neg))
				lim_neg_reg <= 1'b0;
			case (state_reg)
				ST_HOLD: begin
					ready <= 1'b0;
					if (do_return) begin
						state_reg <= ST_MOVE;
						kind_reg <= KIND_POSN;
						step_dir <= ret_dir;
						remain_reg <= ret_dist;
						prof_speed <= r_speed_reg; // R11
						prof_accel <= r_accel_reg;
						prof_start <= r_start_reg;
						step_req <= 1'b1;
					end else begin
						state_reg <= ST_IDLE;
						ready <= !s_stop;
					end
				end
				ST_IDLE: begin
					ready <= !s_stop; // R24
					decel_stop <= 1'b0;
					if (reexcite && do_return) begin
						state_reg <= ST_HOLD;
						ready <= 1'b0;
					end else if (can_start && nudge_req && !nudge_blocked) begin
						state_reg <= ST_MOVE; // R1
						kind_reg <= KIND_POSN;
						step_dir <= nudge_dir; // R2
						remain_reg <= travel_reg;
						prof_speed <= n_speed_reg; // R8
						prof_accel <= n_accel_reg;
						prof_start <= n_start_reg;
						step_req <= 1'b1;
						ready <= 1'b0; // R6
					end else if (can_start && ext_go) begin
						state_reg <= ST_MOVE; // R22
						kind_reg <= KIND_FREE;
						step_dir <= ext_move_dir;
						step_req <= 1'b1;
						ready <= 1'b0;
					end
				end
				ST_MOVE: begin
					ready <= 1'b0;
					if (dir_blocked) begin
						if (step_dir)
							lim_pos_reg <= 1'b1; // R21
						else
							lim_neg_reg <= 1'b1;
						decel_stop <= ot_decel; // R16 R17
						step_req <= 1'b0;
						state_reg <= ot_decel ? ST_DECEL : ST_IDLE;
						last_stop_reg <= pos_now;
					end else if (s_stop || stop_cmd_reg || limit_chg_reg) begin
						decel_stop <= limit_chg_reg ? ot_decel : 1'b1; // R14 R20
						step_req <= 1'b0;
						state_reg <= ST_DECEL;
						last_stop_reg <= pos_now;
					end else if (kind_reg == KIND_FREE && !ext_go) begin
						step_req <= 1'b0;
						state_reg <= ST_IDLE;
						last_stop_reg <= pos_now;
					end else if (kind_reg == KIND_POSN && step_done) begin
						if (remain_reg == {{(POS_W-1){1'b0}}, 1'b1}) begin
							step_req <= 1'b0;
							state_reg <= ST_IDLE; // R6
							last_stop_reg <= pos_now;
						end else begin
							remain_reg <= remain_reg - 1'b1;
						end
					end
				end
				ST_DECEL: begin
					ready <= 1'b0;
					decel_stop <= 1'b0;
					state_reg <= ST_IDLE;
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end
endmodule

// ---- motion_aux_props.sv ----
module motion_aux_props #(
	parameter POS_W = 24,
	parameter SPD_W = 20
) (
	// Clock and reset
	input wire ref_clk,
	input wire sys_rst,
	// Host pins
	input wire nudge_positive_input,
	input wire nudge_negative_input,
	input wire stop_input,
	input wire [1:0] limit_sensor_inputs,
	// Outputs watched
	input wire ready,
	input wire step_req,
	input wire step_dir,
	input wire [SPD_W-1:0] prof_speed,
	input wire teach_wr,
	input wire [POS_W:0] teach_data
);
	// ==========================================
	// Sequences
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	sequence nudge_go;
		$rose(nudge_positive_input) && ready && !stop_input && limit_sensor_inputs == 2'h0;
	endsequence
	sequence stop_held;
		stop_input [*4];
	endsequence
	sequence move_done;
		$fell(step_req) && !stop_input && limit_sensor_inputs == 2'h0;
	endsequence
	// ==========================================
	// Properties
	a_nudge_start_delay: assert property (nudge_go |-> ##[2:4] (step_req && !ready))
		else $error("nudge start not seen in time");
	a_ready_low_move: assert property (step_req |-> !ready)
		else $error("ready high during move");
	a_ready_after_done: assert property (move_done |=> ready)
		else $error("ready not back after move");
	a_stop_blocks_ready: assert property (stop_held |-> !ready)
		else $error("ready high while stop held");
	a_stop_halts_move: assert property (stop_held |-> !step_req)
		else $error("motion while stop held");
	a_pos_limit_stop: assert property (limit_sensor_inputs[0] [*4] |-> !(step_req && step_dir))
		else $error("positive motion at positive limit");
	a_neg_limit_stop: assert property (limit_sensor_inputs[1] [*4] |-> !(step_req && !step_dir))
		else $error("negative motion at negative limit");
	a_dir_positive: assert property ($rose(step_req) && nudge_positive_input |-> step_dir)
		else $error("wrong direction positive");
	a_dir_negative: assert property ($rose(step_req) && nudge_negative_input |-> !step_dir)
		else $error("wrong direction negative");
	a_profile_steady: assert property (step_req && $past(step_req) |-> $stable(prof_speed))
		else $error("profile changed during move");
	a_teach_abs_mode: assert property (teach_wr |-> teach_data[POS_W])
		else $error("taught entry not absolute");
endmodule
bind motion_aux_stop_limit_control motion_aux_props #(.POS_W(POS_W), .SPD_W(SPD_W)) motion_aux_props_i (
	.ref_clk, .sys_rst, .nudge_positive_input, .nudge_negative_input, .stop_input, .limit_sensor_inputs,
	.ready, .step_req, .step_dir, .prof_speed, .teach_wr, .teach_data);

// ---- motion_engine_model.sv ----
module motion_engine_model (
	// Clock and reset
	input wire ref_clk,
	input wire sys_rst,
	// Step handshake
	input wire step_req,
	input wire [3:0] gap,
	output logic step_done
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt;
	// ==========================================
	// One step every gap+1 cycles while requested
	always @(posedge ref_clk) begin
		if (sys_rst || !step_req) begin
			cnt <= 4'h0;
			step_done <= 1'b0;
		end else if (cnt >= gap) begin
			cnt <= 4'h0;
			step_done <= 1'b1;
		end else begin
			cnt <= cnt + 4'h1;
			step_done <= 1'b0;
		end
	end
endmodule

// ---- tb_motion_aux_stop_limit_control.sv ----
`include "motion_aux_consts.vh"
module tb_motion_aux_stop_limit_control;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'b0, sys_rst = 1'b1, nudge_positive_input = 1'b0, nudge_negative_input = 1'b0;
	logic stop_input = 1'b0, preset_input = 1'b0, home_done = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic excite_on_input = 1'b0, ext_move_dir = 1'b0;
	logic [1:0] limit_sensor_inputs = 2'h0, ext_move_req = 2'h0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_val, stop_pos;
	logic ready, step_req, step_dir, decel_stop, teach_wr, step_done, t_seen = 1'b0;
	logic [19:0] prof_speed, prof_accel, prof_start;
	logic [5:0] teach_index, t_index;
	logic [24:0] teach_data, t_data;
	logic [3:0] gap = 4'h1;
	int miscompares = 0, check_count = 0, steps = 0, steps_base = 0, decels = 0;
	logic [31:0] rst_tab [0:10] = '{32'h1, 32'h3e8, 32'h3e8, 32'h1f4, 32'h0, 32'h3e8, 32'h3e8, 32'h1f4,
		32'h5, 32'h7fffff, 32'hff800000};
	motion_aux_stop_limit_control motion_aux_stop_limit_control_i (.ref_clk, .sys_rst, .nudge_positive_input,
		.nudge_negative_input, .stop_input, .excite_on_input, .free_run_input(1'b0), .preset_input,
		.limit_sensor_inputs, .home_done, .alarm_active(1'b0), .step_done, .ext_move_req,
		.ext_move_dir, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ready, .step_req, .step_dir,
		.decel_stop, .prof_speed, .prof_accel, .prof_start, .teach_wr, .teach_index, .teach_data);
	motion_engine_model motion_engine_model_i (.ref_clk, .sys_rst, .step_req, .gap, .step_done);
	always #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		if (step_done === 1'b1) steps <= steps + 1;
		if (decel_stop === 1'b1) decels <= decels + 1;
		if (teach_wr === 1'b1) begin
			t_seen <= 1'b1;
			t_index <= teach_index;
			t_data <= teach_data;
		end
	end
	// ==========================================
	// Checking and closing
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic wait_ready();
		int n;
		n = 0;
		while (ready !== 1'b1) begin
			@(posedge ref_clk);
			#1;
			n++;
			if (n > 3000) begin
				check("ready wait", 32'h0, 32'h1);
				finish_test();
			end
		end
	endtask
	// ==========================================
	// Register port and pins
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(posedge ref_clk);
		d = reg_rdata;
	endtask
	task automatic nudge(input logic pos, input bit go);
		int n;
		@(posedge ref_clk);
		steps_base = steps;
		if (pos) nudge_positive_input <= 1'b1;
		else nudge_negative_input <= 1'b1;
		for (n = 0; n < 10 && !(go && ready === 1'b0); n++) begin
			@(posedge ref_clk);
			#1;
			if (!go) check("refused", {31'h0, step_req}, 32'h0);
		end
		if (go) check("started", {30'h0, ready, step_dir}, {31'h0, pos});
		@(posedge ref_clk);
		nudge_positive_input <= 1'b0;
		nudge_negative_input <= 1'b0;
	endtask
	// ==========================================
	// Main sequence
	initial begin
		repeat (8) @(posedge ref_clk);
		sys_rst <= 1'b0;
		for (int i = 0; i < 11; i++) begin
			rd(8'(4 * i), rd_val);
			check("reset value", rd_val, rst_tab[i]);
		end
		wr(8'h40, 32'h5a5a5a5a);
		rd(8'h40, rd_val);
		check("unmapped", rd_val, 32'h0);
		wr(`ADDR_NUDGE_TRAVEL, 32'h3);
		wr(`ADDR_NUDGE_SPEED, 32'h309);
		@(posedge ref_clk);
		preset_input <= 1'b1;
		repeat (4) @(posedge ref_clk);
		preset_input <= 1'b0;
		wait_ready();
		nudge(1'b1, 1'b1);
		check("speed", {12'h0, prof_speed}, 32'h309);
		check("profile", {prof_accel[15:0], prof_start[15:0]}, 32'h03e801f4);
		wait_ready();
		check("steps", 32'(steps - steps_base), 32'h3);
		rd(`ADDR_POSITION, rd_val);
		check("position", rd_val, 32'h3);
		nudge(1'b0, 1'b1);
		wait_ready();
		check("steps", 32'(steps - steps_base), 32'h3);
		rd(`ADDR_POSITION, rd_val);
		check("position", rd_val, 32'h0);
		wr(`ADDR_TEACH, 32'h5);
		repeat (3) @(posedge ref_clk);
		check("teach", {t_seen, t_index, t_data}, {1'b1, 6'h05, 25'h1000000});
		@(posedge ref_clk);
		home_done <= 1'b1;
		@(posedge ref_clk);
		home_done <= 1'b0;
		wr(`ADDR_SOFT_POS, 32'h2);
		wr(`ADDR_NUDGE_TRAVEL, 32'h5);
		wait_ready();
		nudge(1'b1, 1'b1);
		wait_ready();
		rd(`ADDR_POSITION, rd_val);
		check("soft limit", rd_val, 32'h2);
		wr(`ADDR_SOFT_POS, 32'h7fffff);
		wr(`ADDR_NUDGE_TRAVEL, 32'h64);
		gap <= 4'h6;
		wait_ready();
		nudge(1'b1, 1'b1);
		repeat (10) @(posedge ref_clk);
		stop_input <= 1'b1;
		repeat (6) @(posedge ref_clk);
		#1;
		check("stopped", {30'h0, step_req, ready}, 32'h0);
		check("decel count", 32'(decels), 32'h1);
		nudge(1'b1, 1'b0);
		stop_input <= 1'b0;
		wait_ready();
		nudge(1'b0, 1'b1);
		repeat (10) @(posedge ref_clk);
		limit_sensor_inputs <= 2'b10;
		repeat (6) @(posedge ref_clk);
		#1;
		check("limit stop", {31'h0, step_req}, 32'h0);
		check("decel count", 32'(decels), 32'h1);
		nudge(1'b0, 1'b0);
		nudge(1'b1, 1'b0);
		gap <= 4'h1;
		ext_move_dir <= 1'b1;
		ext_move_req <= 2'h1;
		repeat (20) @(posedge ref_clk);
		#1;
		check("escape", {31'h0, step_req}, 32'h1);
		@(posedge ref_clk);
		ext_move_req <= 2'h0;
		limit_sensor_inputs <= 2'h0;
		wait_ready();
		rd(`ADDR_POSITION, stop_pos);
		@(posedge ref_clk);
		preset_input <= 1'b1;
		repeat (4) @(posedge ref_clk);
		preset_input <= 1'b0;
		wr(`ADDR_RET_CTRL, 32'h1);
		excite_on_input <= 1'b1;
		repeat (6) @(posedge ref_clk);
		wait_ready();
		rd(`ADDR_POSITION, rd_val);
		check("return", rd_val, stop_pos);
		check("return speed", {12'h0, prof_speed}, 32'h3e8);
		finish_test();
	end
endmodule
